// ==== hdl/pio_pkg.sv ====
// Constants and state type for the programmable I/O port bank.
package pio_pkg;

  // Pin and group geometry (port n bit b is pin index n*8+b).
  localparam int        PIO_NPINS       = 88;
  localparam int        PIO_NGROUPS     = 22;
  localparam int        PIO_GROUP_W     = 4;
  localparam logic [3:0] PIO_NPORTS     = 4'hb;
  localparam int        PIO_IN_ONLY_PIN = 69;
  localparam int        PIO_RB_PORT     = 1;

  // Analog output pin positions; plain defaults.
  localparam int PIO_DAC0_PIN = 72;
  localparam int PIO_DAC1_PIN = 73;

  localparam logic [87:0] PIO_IN_ONLY_MASK = 88'h1 << PIO_IN_ONLY_PIN;
  localparam logic [87:0] PIO_RB_MASK      = 88'hff << (PIO_RB_PORT * 8);
  localparam logic [87:0] PIO_DAC0_MASK    = 88'h1 << PIO_DAC0_PIN;
  localparam logic [87:0] PIO_DAC1_MASK    = 88'h1 << PIO_DAC1_PIN;

  // Groups whose pull-ups are cut in the external bus modes:
  // ports zero to three, port_four_bit_zero..three, port_five.
  localparam logic [21:0] PIO_PULL_LOCK = 22'h000dff;

  // Register byte addresses.
  localparam logic [11:0] PIO_PORT_BASE = 12'h000;
  localparam logic [11:0] PIO_DIR_BASE  = 12'h040;
  localparam logic [11:0] PIO_PULL_OFS  = 12'h080;
  localparam logic [11:0] PIO_CTRL_OFS  = 12'h084;
  localparam logic [11:0] PIO_STAT_OFS  = 12'h088;

  // Field positions.
  localparam int PIO_CTRL_RB_BIT   = 0;
  localparam int PIO_STAT_MODE_LSB = 0;
  localparam int PIO_STAT_BUS8_BIT = 2;
  localparam int PIO_STAT_MUX_BIT  = 3;
  localparam int PIO_STAT_RBV_BIT  = 4;

  // Processor operating modes.
  localparam logic [1:0] PIO_MODE_SINGLE = 2'h0;
  localparam logic [1:0] PIO_MODE_MEMEXP = 2'h1;
  localparam logic [1:0] PIO_MODE_MICRO  = 2'h3;

  // Reset values.
  localparam logic [87:0] PIO_LATCH_RST = 88'h0;
  localparam logic [87:0] PIO_DIR_RST   = 88'h0;
  localparam logic [21:0] PIO_PULL_RST  = 22'h0;
  localparam logic        PIO_CTRL_RST  = 1'b0;
  localparam logic [31:0] PIO_RDATA_RST = 32'h0;

  typedef struct packed {
    logic [87:0] latch;
    logic [87:0] dir;
    logic [21:0] pull;
    logic        rb_latch;
    logic [31:0] rdata;
    logic        slverr;
  } pio_state_t;

endpackage

// ==== hdl/pio_port_bank.sv ====
// Programmable I/O port bank with APB register access.
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps

module pio_port_bank
  import pio_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  proc_mode,
  input  wire logic        bus_8bit,
  input  wire logic        mux_bus_all,
  input  wire logic [87:0] ext_bus_pins,
  input  wire logic [87:0] periph_out_en,
  input  wire logic [87:0] periph_out,
  input  wire logic [1:0]  dac_out_en,
  input  wire logic [87:0] pin_in,
  output logic      [87:0] pin_out,
  output logic      [87:0] pin_oe,
  output logic      [87:0] pin_pullup
);

  pio_state_t  st;
  pio_state_t  next_st;

  logic        ext_mode;
  logic        rb_valid;
  logic [87:0] bus_lock;
  logic [87:0] rb_force;
  logic [87:0] readback;
  logic [21:0] pull_eff;
  logic [87:0] pull_exp;
  logic [87:0] dac_mask;
  logic [87:0] port_mask;
  logic [87:0] wdata_rep;
  logic [3:0]  idx;
  logic        setup;
  logic        wr_acc;
  logic        hit_port;
  logic        hit_dir;
  logic        hit_pull;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        bad;
  logic [31:0] rd_word;

  assign ext_mode = proc_mode != PIO_MODE_SINGLE;
  // Select is meaningful only when port one is free of the bus
  assign rb_valid = ext_mode && (bus_8bit || mux_bus_all);
  assign bus_lock = ext_mode ? ext_bus_pins : 88'h0;
  assign rb_force = (rb_valid && st.rb_latch) ? PIO_RB_MASK : 88'h0;

  // Outputs and forced-latch bits read the latch; inputs read the pin
  assign readback = ((st.dir | rb_force) & st.latch)
                  | (~(st.dir | rb_force) & pin_in);

  assign pull_eff = st.pull & ~(ext_mode ? PIO_PULL_LOCK : 22'h0);

  genvar g;
  generate
    for (g = 0; g < PIO_NGROUPS; g++) begin : g_pull
      assign pull_exp[g*PIO_GROUP_W +: PIO_GROUP_W] =
        {PIO_GROUP_W{pull_eff[g]}};
    end
  endgenerate

  assign dac_mask = ({88{dac_out_en[0]}} & PIO_DAC0_MASK)
                  | ({88{dac_out_en[1]}} & PIO_DAC1_MASK);

  // Pin drive
  assign pin_oe = (st.dir | periph_out_en)
                & ~PIO_IN_ONLY_MASK;
  assign pin_out = (periph_out_en & periph_out)
                 | (~periph_out_en & st.latch);
  assign pin_pullup = pull_exp & ~st.dir & ~dac_mask
                    & ~PIO_IN_ONLY_MASK;

  // Bus handshake: zero wait states, data prepared in the setup cycle
  assign pready  = 1'b1;
  assign prdata  = st.rdata;
  assign pslverr = st.slverr;

  assign idx       = paddr[5:2];
  assign setup     = psel && !penable;
  assign wr_acc    = psel && penable && pwrite;
  assign port_mask = 88'hff << {idx, 3'b000};
  assign wdata_rep = {11{pwdata[7:0]}};

  // Address decode
  always_comb begin
    hit_port = 1'b0;
    hit_dir  = 1'b0;
    hit_pull = 1'b0;
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    bad      = 1'b0;
    if (paddr[1:0] != 2'b00) begin
      bad = 1'b1;
    end else if (paddr[11:6] == PIO_PORT_BASE[11:6] && idx < PIO_NPORTS) begin
      hit_port = 1'b1;
    end else if (paddr[11:6] == PIO_DIR_BASE[11:6] && idx < PIO_NPORTS) begin
      hit_dir = 1'b1;
    end else if (paddr == PIO_PULL_OFS) begin
      hit_pull = 1'b1;
    end else if (paddr == PIO_CTRL_OFS) begin
      hit_ctrl = 1'b1;
    end else if (paddr == PIO_STAT_OFS) begin
      hit_stat = 1'b1;
    end else begin
      bad = 1'b1;
    end
  end

  // Read mux; unused upper bits read zero
  always_comb begin
    rd_word = 32'h0;
    if (hit_port) begin
      rd_word[7:0] = readback[{idx, 3'b000} +: 8];
    end else if (hit_dir) begin
      rd_word[7:0] = st.dir[{idx, 3'b000} +: 8];
    end else if (hit_pull) begin
      rd_word[21:0] = st.pull;
    end else if (hit_ctrl) begin
      rd_word[PIO_CTRL_RB_BIT] = st.rb_latch;
    end else if (hit_stat) begin
      rd_word[PIO_STAT_MODE_LSB +: 2] = proc_mode;
      rd_word[PIO_STAT_BUS8_BIT]      = bus_8bit;
      rd_word[PIO_STAT_MUX_BIT]       = mux_bus_all;
      rd_word[PIO_STAT_RBV_BIT]       = rb_valid;
    end
  end

  always_comb begin
    next_st = st;
    if (setup) begin
      next_st.rdata  = pwrite ? 32'h0 : rd_word;
      next_st.slverr = bad;
    end
    if (wr_acc && hit_port) begin
      // Bus-owned pins keep their latch in external modes
      next_st.latch = (st.latch & ~(port_mask & ~bus_lock))
                    | (wdata_rep & port_mask & ~bus_lock);
    end
    if (wr_acc && hit_dir) begin
      // No direction bit exists for the input-only pin
      next_st.dir = (st.dir & ~(port_mask & ~bus_lock & ~PIO_IN_ONLY_MASK))
                  | (wdata_rep & port_mask & ~bus_lock
                     & ~PIO_IN_ONLY_MASK);
    end
    if (wr_acc && hit_pull) begin
      next_st.pull = pwdata[21:0];
    end
    if (wr_acc && hit_ctrl) begin
      next_st.rb_latch = pwdata[PIO_CTRL_RB_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.latch    <= PIO_LATCH_RST;
      st.dir      <= PIO_DIR_RST;
      st.pull     <= PIO_PULL_RST;
      st.rb_latch <= PIO_CTRL_RST;
      st.rdata    <= PIO_RDATA_RST;
      st.slverr   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_dir_write;
    psel && penable && pwrite && hit_dir;
  endsequence

  sequence s_port_write;
    psel && penable && pwrite && hit_port;
  endsequence

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_p1_read;
    psel && !penable && !pwrite && hit_port && idx == 4'h1;
  endsequence

  property p_in_only_pin;
    !pin_oe[PIO_IN_ONLY_PIN] && !pin_pullup[PIO_IN_ONLY_PIN]
      && !st.dir[PIO_IN_ONLY_PIN];
  endproperty
  a_in_only_pin: assert property (p_in_only_pin)
    else $error("input-only pin driven or pulled up");

  property p_periph_drive;
    ((periph_out_en & ~PIO_IN_ONLY_MASK & ~pin_oe) == 88'h0)
      && (((pin_out ^ periph_out) & periph_out_en) == 88'h0);
  endproperty
  a_periph_drive: assert property (p_periph_drive)
    else $error("peripheral output not driven on pin");

  property p_pull_input_only;
    (pin_pullup & pin_oe & ~periph_out_en) == 88'h0;
  endproperty
  a_pull_input_only: assert property (p_pull_input_only)
    else $error("pull-up on output pin");

  property p_dir_locked;
    s_dir_write |=> ((st.dir ^ $past(st.dir)) & $past(bus_lock)) == 88'h0;
  endproperty
  a_dir_locked: assert property (p_dir_locked)
    else $error("bus pin direction modified");

  property p_dir_takes;
    s_dir_write ##0 (proc_mode == PIO_MODE_SINGLE) && idx == 4'h0
      |=> st.dir[7:0] == $past(pwdata[7:0]);
  endproperty
  a_dir_takes: assert property (p_dir_takes)
    else $error("direction write did not take");

  property p_latch_locked;
    s_port_write |=> ((st.latch ^ $past(st.latch)) & $past(bus_lock))
      == 88'h0;
  endproperty
  a_latch_locked: assert property (p_latch_locked)
    else $error("bus pin latch modified");

  property p_ext_pull_cut;
    ext_mode |-> (pin_pullup[47:40] == 8'h0) && (pin_pullup[35:0] == 36'h0);
  endproperty
  a_ext_pull_cut: assert property (p_ext_pull_cut)
    else $error("bus port pull-up connected in external mode");

  property p_pull_writable;
    psel && penable && pwrite && hit_pull
      |=> st.pull == $past(pwdata[21:0]);
  endproperty
  a_pull_writable: assert property (p_pull_writable)
    else $error("pull-up control write lost");

  property p_rb_latch;
    s_p1_read ##0 (rb_valid && st.rb_latch)
      |=> prdata[7:0] == $past(st.latch[15:8]);
  endproperty
  a_rb_latch: assert property (p_rb_latch)
    else $error("port one did not read latch");

  property p_rb_pin;
    s_p1_read ##0 !rb_valid
      |=> ((prdata[7:0] ^ $past(pin_in[15:8])) & ~$past(st.dir[15:8]))
          == 8'h0;
  endproperty
  a_rb_pin: assert property (p_rb_pin)
    else $error("port one input did not read pin level");

  property p_dac_no_pull;
    (dac_out_en[0] |-> !pin_pullup[PIO_DAC0_PIN])
      and (dac_out_en[1] |-> !pin_pullup[PIO_DAC1_PIN]);
  endproperty
  a_dac_no_pull: assert property (p_dac_no_pull)
    else $error("pull-up on enabled analog output");

  property p_latch_drive;
    ##1 (((pin_out ^ st.latch) & ~periph_out_en) == 88'h0)
      && (pin_oe == ((st.dir | periph_out_en) & ~PIO_IN_ONLY_MASK));
  endproperty
  a_latch_drive: assert property (p_latch_drive)
    else $error("output pin not driven from latch");

  property p_pready_const;
    pready == 1'b1;
  endproperty
  a_pready_const: assert property (p_pready_const)
    else $error("ready not held high");

  property p_bad_err;
    s_setup ##0 bad |=> pslverr && (prdata == 32'h0);
  endproperty
  a_bad_err: assert property (p_bad_err)
    else $error("unmapped access not flagged");

  property p_bad_no_write;
    psel && penable && pwrite && bad
      |=> $stable(st.latch) && $stable(st.dir) && $stable(st.pull);
  endproperty
  a_bad_no_write: assert property (p_bad_no_write)
    else $error("unmapped write changed state");

  property p_write_rdata_zero;
    s_setup ##0 pwrite |=> prdata == 32'h0;
  endproperty
  a_write_rdata_zero: assert property (p_write_rdata_zero)
    else $error("write returned read data");

  property p_rdata_holds;
    !(psel && !penable) |=> $stable(prdata) && $stable(pslverr);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds)
    else $error("read data changed outside setup");

  property p_port_takes;
    s_port_write ##0 !ext_mode && idx == 4'h1
      |=> st.latch[15:8] == $past(pwdata[7:0]);
  endproperty
  a_port_takes: assert property (p_port_takes)
    else $error("port latch write did not take");

  property p_ctrl_takes;
    psel && penable && pwrite && hit_ctrl
      |=> st.rb_latch == $past(pwdata[PIO_CTRL_RB_BIT]);
  endproperty
  a_ctrl_takes: assert property (p_ctrl_takes)
    else $error("port control write did not take");

  property p_pull_group;
    !ext_mode |-> (pin_pullup & ~pull_exp) == 88'h0;
  endproperty
  a_pull_group: assert property (p_pull_group)
    else $error("pull-up outside its enabled group");

  property p_stat_readonly;
    psel && penable && pwrite && hit_stat |=> $stable(st);
  endproperty
  a_stat_readonly: assert property (p_stat_readonly)
    else $error("status write changed state");

endmodule

// ==== tb/pio_pin_model.sv ====
// Devices and resistors outside the port pins.
`timescale 1ns/1ps

module pio_pin_model (
  input  wire logic        pclk,
  input  wire logic [87:0] pin_out,
  input  wire logic [87:0] pin_oe,
  input  wire logic [87:0] pin_pullup,
  input  wire logic [87:0] ext_en,
  input  wire logic [87:0] ext_val,
  output logic      [87:0] pin_in
);
  // Undriven pins without a pull-up wander, so a stale level never passes for data
  logic flt;

  initial flt = 1'b0;

  always @(posedge pclk) begin
    flt <= ~flt;
  end

  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
           | (~pin_oe & ~ext_en & (pin_pullup | {88{flt}}));
  end
endmodule

// ==== tb/pio_port_bank_tb.sv ====
// Self-checking bench for the programmable I/O port bank.
`timescale 1ns/1ps

module pio_port_bank_tb
  import pio_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        bus_8bit, mux_bus_all;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  proc_mode, dac_out_en;
  logic [87:0] ext_bus_pins, periph_out_en, periph_out, pin_in, pin_out;
  logic [87:0] pin_oe, pin_pullup, ext_en, ext_val, xdir;
  logic [32:0] r;
  int          errors, cmp_count, cyc;

  pio_port_bank DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .proc_mode, .bus_8bit,
    .mux_bus_all, .ext_bus_pins, .periph_out_en, .periph_out,
    .dac_out_en, .pin_in, .pin_out, .pin_oe, .pin_pullup);

  pio_pin_model u_pins (.pclk, .pin_out, .pin_oe, .pin_pullup, .ext_en,
    .ext_val, .pin_in);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Generous ceiling; the whole run needs about 125 cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      end_sim;
    end
  end

  task automatic chk(input logic [87:0] g, input logic [87:0] x);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [32:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [32:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk({55'h0, q}, {56'h0, x});
  endtask

  // Pins settle over three clock cycles
  task automatic tick;
    repeat (3) @(posedge pclk);
    #1;
  endtask

  task automatic done(input string s);
    $display("test %s ended", s);
  endtask

  initial begin
    {presetn, psel, penable, pwrite, bus_8bit, mux_bus_all} = 6'h0;
    {paddr, pwdata, proc_mode, dac_out_en} = 48'h0;
    {ext_bus_pins, periph_out_en, periph_out} = 264'h0;
    ext_en = '1;
    ext_val = {11{8'h96}};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(PIO_DIR_BASE, 32'h0);
    rd(PIO_PULL_OFS, 32'h0);
    rd(PIO_CTRL_OFS, 32'h0);
    chk(pin_oe | pin_pullup, 88'h0);
    done("reset");
    wr(PIO_DIR_BASE, 32'h5a);
    wr(PIO_PORT_BASE, 32'hff);
    wr(PIO_DIR_BASE + 12'h28, 32'h81);
    tick;
    xdir = {8'h81, 16'h0, 56'h0, 8'h5a};
    chk(pin_oe, xdir);
    chk(pin_out & pin_oe, 88'h5a);
    rd(PIO_PORT_BASE, 32'hde);
    rd(PIO_PORT_BASE + 12'h28, 32'h16);
    wr(PIO_DIR_BASE + 12'h20, 32'hff);
    rd(PIO_DIR_BASE + 12'h20, 32'hdf);
    xdir[71:64] = 8'hdf;
    tick;
    chk(pin_oe, xdir);
    done("direction");
    wr(PIO_PULL_OFS, 32'h1);
    tick;
    chk(pin_pullup, 88'h5);
    wr(PIO_PULL_OFS, 32'h3fffff);
    tick;
    chk(pin_pullup, ~xdir & ~PIO_IN_ONLY_MASK);
    done("pullup");
    // Pin 17 stays input while a peripheral drives pin 16
    periph_out_en[16] <= 1'b1;
    periph_out[17:16] <= 2'b11;
    // Analog pins keep input direction throughout
    dac_out_en <= 2'b01;
    tick;
    chk({pin_oe[23:16], pin_out[16]}, 9'h3);
    chk(pin_pullup[79:72], 8'hfe);
    dac_out_en <= 2'b10;
    tick;
    chk(pin_pullup[79:72], 8'hfd);
    done("peripheral");
    proc_mode <= PIO_MODE_MICRO;
    ext_bus_pins <= 88'hff;
    wr(PIO_DIR_BASE, 32'h0);
    wr(PIO_PORT_BASE, 32'h0);
    rd(PIO_DIR_BASE, 32'h5a);
    rd(PIO_PORT_BASE, 32'hde);
    wr(PIO_PULL_OFS, 32'h3ffffe);
    rd(PIO_PULL_OFS, 32'h3ffffe);
    tick;
    chk({pin_pullup[55:48], pin_pullup[39:32], pin_pullup[7:0]},
        24'hfff000);
    done("external bus");
    wr(PIO_PORT_BASE + 12'h4, 32'h3c);
    bus_8bit <= 1'b1;
    wr(PIO_CTRL_OFS, 32'h1);
    rd(PIO_PORT_BASE + 12'h4, 32'h3c);
    wr(PIO_CTRL_OFS, 32'h0);
    rd(PIO_PORT_BASE + 12'h4, 32'h96);
    wr(PIO_CTRL_OFS, 32'h1);
    bus_8bit <= 1'b0;
    rd(PIO_PORT_BASE + 12'h4, 32'h96);
    mux_bus_all <= 1'b1;
    rd(PIO_PORT_BASE + 12'h4, 32'h3c);
    proc_mode <= PIO_MODE_SINGLE;
    rd(PIO_PORT_BASE + 12'h4, 32'h96);
    rd(PIO_STAT_OFS, 32'h8);
    done("readback");
    xfer(1'b0, 12'h100, 32'h0, r);
    chk({55'h0, r}, {56'h1, 32'h0});
    done("unmapped");
    end_sim;
  end
endmodule
